//--- pkg/dtc_pkg.sv
// Shared constants for the dual timer with capture/reload block.
// Assumes a 32-bit APB master and a single 25 MHz system clock.
package dtc_pkg;
   localparam int          DTC_TW        = 16;       // Timer width
   localparam int          DTC_AW        = 8;        // APB address width
   localparam int          DTC_PSW       = 4;        // Prescaler exponent width
   localparam int          DTC_MIN_RES   = 2;        // Finest resolution in clocks
   // Register byte addresses
   localparam logic [7:0]  ADDR_AUX_CTL  = 8'h00;
   localparam logic [7:0]  ADDR_CORE_CTL = 8'h04;
   localparam logic [7:0]  ADDR_PRESC    = 8'h08;
   localparam logic [7:0]  ADDR_AUX_CNT  = 8'h0C;
   localparam logic [7:0]  ADDR_CORE_CNT = 8'h10;
   localparam logic [7:0]  ADDR_CAPTURE_RELOAD_REGISTER   = 8'h14;
   localparam logic [7:0]  ADDR_CAP_CTL  = 8'h18;
   localparam logic [7:0]  ADDR_INT_STAT = 8'h1C;
   localparam logic [7:0]  ADDR_INT_EN   = 8'h20;
   localparam logic [7:0]  ADDR_INT_CLR  = 8'h24;
   // Timer control fields
   localparam int          CTL_SRC_LSB   = 0;        // 2-bit clock source
   localparam int          CTL_DOWN      = 2;        // Software direction, 1 = down
   localparam int          CTL_EXTDIR    = 3;        // Direction from input level
   localparam int          CTL_RUN       = 4;        // Timer runs
   localparam int          CTL_RELOAD    = 5;        // Core only: reload on wrap
   localparam int          CTL_W         = 6;
   localparam logic [5:0]  CTL_RST       = 6'h00;
   // Capture control fields
   localparam int          CAP_EDGE_LSB  = 0;        // Bit0 rising, bit1 falling
   localparam int          CAP_SRC_LSB   = 2;        // 2-bit trigger source
   localparam int          CAP_CLR       = 4;        // Clear aux after capture
   localparam int          CAP_EN        = 5;        // Capture enabled
   localparam int          CAP_W         = 6;
   localparam logic [5:0]  CAP_RST       = 6'h00;
   localparam logic [3:0]  PRESC_RST     = 4'h0;
   localparam logic [15:0] CNT_RST       = 16'h0000;
   // Interrupt event bits
   localparam int          INT_CORE_WRAP = 0;
   localparam int          INT_AUX_WRAP  = 1;
   localparam int          INT_CAPTURE   = 2;
   localparam int          INT_W         = 3;
   // Synchronised input slots
   localparam int          SY_CAP        = 0;
   localparam int          SY_AUX_CLK    = 1;
   localparam int          SY_AUX_DIR    = 2;
   localparam int          SY_FM_CNT     = 3;
   localparam int          SY_FM_DIR     = 4;
   localparam int          SY_CORE_CLK   = 5;
   localparam int          SY_CORE_DIR   = 6;
   localparam int          SY_N          = 7;
   // Timer clock sources
   typedef enum logic [1:0] {
      SRC_PRESC = 2'h0,
      SRC_EXT   = 2'h1,
      SRC_TL    = 2'h2,
      SRC_NONE  = 2'h3
   } dtc_src_t;
   // Capture trigger sources
   typedef enum logic [1:0] {
      CSRC_PIN  = 2'h0,
      CSRC_FCNT = 2'h1,
      CSRC_FDIR = 2'h2,
      CSRC_FBOT = 2'h3
   } dtc_csrc_t;
endpackage

//--- src/dtc_sync.sv
// Two-flop synchronisers with edge detection for a group of inputs.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module dtc_sync #(
   parameter int W = 7
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);
   // All state of the synchroniser
   typedef struct packed {
      logic [W-1:0] meta;   // First stage, read only by second stage
      logic [W-1:0] sync;   // Second stage
      logic [W-1:0] last;   // Previous synchronised level
   } dtc_sync_st_t;
   dtc_sync_st_t s_r;
   dtc_sync_st_t s_nxt;

   // Shift the chain each clock
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.meta = i_async;
      s_nxt.sync = s_r.meta;
      s_nxt.last = s_r.sync;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Edges compare stage two with stage three, never the first stage
   assign o_level = s_r.sync;
   assign o_rise  = s_r.sync & ~s_r.last;
   assign o_fall  = ~s_r.sync & s_r.last;
endmodule
`default_nettype wire

//--- src/dtc_presc.sv
// Programmable prescaler: one-cycle tick every 2^(n+1) clocks.
// Assumes i_exp is a register on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dtc_presc
   import dtc_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_reset_n,
   input  wire logic [DTC_PSW-1:0] i_exp,
   output logic                    o_tick
);
   // All state of the prescaler
   typedef struct packed {
      logic [DTC_TW-1:0] cnt;   // Free-running divider
      logic              tick;  // Registered tick
   } dtc_presc_st_t;
   dtc_presc_st_t     s_r;
   dtc_presc_st_t     s_nxt;
   logic [DTC_TW-1:0] mask;

   // Smallest period is two clocks, so timers never resolve finer
   always_comb
   begin
      mask       = DTC_TW'((32'h2 << i_exp) - 32'h1);
      s_nxt      = s_r;
      s_nxt.cnt  = s_r.cnt + 16'h0001;
      s_nxt.tick = (s_r.cnt & mask) == mask;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign o_tick = s_r.tick;
endmodule
`default_nettype wire

//--- src/dtc_top.sv
// Second timer module: aux timer, core timer, capture/reload register, APB.
// Assumes an APB3 master on I_CLK; all event pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module dtc_top
   import dtc_pkg::*;
(
   input  wire logic                     I_CLK,
   input  wire logic                     I_RESET_N,
   input  wire logic                     I_PSEL,
   input  wire logic                     I_PENABLE,
   input  wire logic                     I_PWRITE,
   input  wire logic [dtc_pkg::DTC_AW-1:0] I_PADDR,
   input  wire logic [31:0]              I_PWDATA,
   output logic      [31:0]              O_PRDATA,
   output logic                          O_PREADY,
   output logic                          O_PSLVERR,
   input  wire logic                     I_CAPTURE_INPUT,
   input  wire logic                     I_AUX_CLOCK_INPUT,
   input  wire logic                     I_AUX_DIRECTION_INPUT,
   input  wire logic                     I_FIRST_MODULE_COUNT_INPUT,
   input  wire logic                     I_FIRST_MODULE_DIRECTION_INPUT,
   input  wire logic                     I_CORE_TIMER_CLOCK_INPUT,
   input  wire logic                     I_CORE_TIMER_DIRECTION_INPUT,
   output logic                          O_TOGGLE_LATCH_OUTPUT,
   output logic                          O_CC_UNIT_TIMERS_CLK,
   output logic                          O_IRQ
);
   import dtc_pkg::*;

   // All block state; both timers sixteen bits
   typedef struct packed {
      logic [CTL_W-1:0]   aux_ctl;     // Aux timer control
      logic [CTL_W-1:0]   core_ctl;    // Core timer control
      logic [DTC_PSW-1:0] presc;       // Prescaler exponent
      logic [CAP_W-1:0]   cap_ctl;     // Capture control
      logic [DTC_TW-1:0]  aux_cnt;     // Aux timer
      logic [DTC_TW-1:0]  core_cnt;    // Core timer
      logic [DTC_TW-1:0]  capture_reload_register;      // Capture/reload register
      logic               tl;          // Core toggle latch
      logic               core_wrap;   // Registered core wrap pulse
      logic [INT_W-1:0]   int_stat;    // Sticky events
      logic [INT_W-1:0]   int_en;      // Event enables
      logic               irq;         // Interrupt line
      logic [31:0]        prdata;      // Read data
      logic               pready;      // Access-phase answer
      logic               pslverr;     // Unmapped address flag
   } dtc_st_t;
   dtc_st_t s_r;
   dtc_st_t s_nxt;

   logic [SY_N-1:0] sy_lvl;       // Synchronised levels
   logic [SY_N-1:0] sy_rise;      // Synchronised rising edges
   logic [SY_N-1:0] sy_fall;      // Synchronised falling edges
   logic            presc_tick;   // Prescaler tick

   // Core clock and direction come from on-chip logic, not pins, but are
   // still synchronised since their source timing is unknown
   dtc_sync #(
      .W (SY_N)
   ) u_sync (
      .i_clk     (I_CLK),
      .i_reset_n (I_RESET_N),
      .i_async   ({I_CORE_TIMER_DIRECTION_INPUT, I_CORE_TIMER_CLOCK_INPUT,
                   I_FIRST_MODULE_DIRECTION_INPUT, I_FIRST_MODULE_COUNT_INPUT,
                   I_AUX_DIRECTION_INPUT, I_AUX_CLOCK_INPUT, I_CAPTURE_INPUT}),
      .o_level   (sy_lvl),
      .o_rise    (sy_rise),
      .o_fall    (sy_fall)
   );

   // Shared prescaler for both timers
   dtc_presc u_presc (
      .i_clk     (I_CLK),
      .i_reset_n (I_RESET_N),
      .i_exp     (s_r.presc),
      .o_tick    (presc_tick)
   );

   // Pick the count pulse for a timer from its configured source
   function automatic logic pick_tick(
      input logic [1:0] src,
      input logic       ptick,
      input logic       ext,
      input logic       tlc
   );
      logic t;
      t = 1'b0;
      case (dtc_src_t'(src))
         SRC_PRESC: t = ptick;
         SRC_EXT:   t = ext;
         SRC_TL:    t = tlc;
         default:   t = 1'b0;
      endcase
      return t;
   endfunction

   // Working signals of the combinational process
   logic                access;      // Access phase present
   logic                wr;          // Write completes this edge
   logic                rd_go;       // Access answered next edge, read or write
   logic                aux_down;    // Aux direction
   logic                core_down;   // Core direction
   logic                aux_tick;    // Aux counts this cycle
   logic                core_tick;   // Core counts this cycle
   logic                aux_wrap;    // Aux wraps this cycle
   logic                core_wrap;   // Core wraps this cycle
   logic                src_rise;    // Rising edge on capture source
   logic                src_fall;    // Falling edge on capture source
   logic                cap_trig;    // Capture fires
   logic [INT_W-1:0]    events;      // New event pulses
   logic [INT_W-1:0]    clr_mask;    // Software clear bits
   logic [DTC_TW-1:0]   wdata16;     // Low half of write data

   // Next-state logic for bus, timers, capture and interrupts
   always_comb
   begin
      s_nxt     = s_r;
      access    = I_PSEL & I_PENABLE;
      wr        = access & I_PWRITE & s_r.pready;
      rd_go     = access & ~s_r.pready;
      wdata16   = I_PWDATA[DTC_TW-1:0];
      clr_mask  = '0;

      // Direction: input level high means count down
      aux_down  = s_r.aux_ctl[CTL_EXTDIR] ? sy_lvl[SY_AUX_DIR] : s_r.aux_ctl[CTL_DOWN];
      core_down = s_r.core_ctl[CTL_EXTDIR] ? sy_lvl[SY_CORE_DIR]
                                           : s_r.core_ctl[CTL_DOWN];

      // Clock source selection aux may follow latch changes
      aux_tick  = s_r.aux_ctl[CTL_RUN] &
                  pick_tick(s_r.aux_ctl[CTL_SRC_LSB +: 2], presc_tick,
                            sy_rise[SY_AUX_CLK], s_r.core_wrap);
      core_tick = s_r.core_ctl[CTL_RUN] &
                  pick_tick(s_r.core_ctl[CTL_SRC_LSB +: 2], presc_tick,
                            sy_rise[SY_CORE_CLK], 1'b0);

      aux_wrap  = aux_tick & (aux_down ? (s_r.aux_cnt == 16'h0000)
                                       : (s_r.aux_cnt == 16'hFFFF));
      core_wrap = core_tick & (core_down ? (s_r.core_cnt == 16'h0000)
                                         : (s_r.core_cnt == 16'hFFFF));

      // Capture source and edge qualification
      case (dtc_csrc_t'(s_r.cap_ctl[CAP_SRC_LSB +: 2]))
         CSRC_PIN:
         begin
            src_rise = sy_rise[SY_CAP];
            src_fall = sy_fall[SY_CAP];
         end
         CSRC_FCNT:
         begin
            src_rise = sy_rise[SY_FM_CNT];
            src_fall = sy_fall[SY_FM_CNT];
         end
         CSRC_FDIR:
         begin
            src_rise = sy_rise[SY_FM_DIR];
            src_fall = sy_fall[SY_FM_DIR];
         end
         default:
         begin
            src_rise = sy_rise[SY_FM_CNT] | sy_rise[SY_FM_DIR];
            src_fall = sy_fall[SY_FM_CNT] | sy_fall[SY_FM_DIR];
         end
      endcase
      cap_trig = s_r.cap_ctl[CAP_EN] &
                 ((s_r.cap_ctl[CAP_EDGE_LSB] & src_rise) |
                  (s_r.cap_ctl[CAP_EDGE_LSB + 1] & src_fall));

      // Core timer: on a wrap either reload or roll over
      if (core_wrap && s_r.core_ctl[CTL_RELOAD])
         s_nxt.core_cnt = s_r.capture_reload_register;
      else if (core_tick)
         s_nxt.core_cnt = core_down ? s_r.core_cnt - 16'h0001
                                    : s_r.core_cnt + 16'h0001;
      // Toggle latch inverts on every wrap
      if (core_wrap)
         s_nxt.tl = ~s_r.tl;
      // Registered wrap pulse feeds aux and outward clock; the interrupt takes the unregistered wrap
      s_nxt.core_wrap = core_wrap;

      // Aux timer: clear after capture beats counting
      if (cap_trig && s_r.cap_ctl[CAP_CLR])
         s_nxt.aux_cnt = CNT_RST;
      else if (aux_tick)
         s_nxt.aux_cnt = aux_down ? s_r.aux_cnt - 16'h0001
                                  : s_r.aux_cnt + 16'h0001;

      // Software writes; counters take the written value over counting
      if (wr)
      begin
         case (I_PADDR)
            ADDR_AUX_CTL:  s_nxt.aux_ctl  = I_PWDATA[CTL_W-1:0];
            ADDR_CORE_CTL: s_nxt.core_ctl = I_PWDATA[CTL_W-1:0];
            ADDR_PRESC:    s_nxt.presc    = I_PWDATA[DTC_PSW-1:0];
            ADDR_CAP_CTL:  s_nxt.cap_ctl  = I_PWDATA[CAP_W-1:0];
            ADDR_AUX_CNT:  s_nxt.aux_cnt  = wdata16;
            ADDR_CORE_CNT: s_nxt.core_cnt = wdata16;
            ADDR_CAPTURE_RELOAD_REGISTER:   s_nxt.capture_reload_register   = wdata16;
            ADDR_INT_EN:   s_nxt.int_en   = I_PWDATA[INT_W-1:0];
            ADDR_INT_CLR:  clr_mask       = I_PWDATA[INT_W-1:0];
            default:       s_nxt.int_en   = s_r.int_en;
         endcase
      end

      // Capture wins over a software write to the same register
      if (cap_trig)
         s_nxt.capture_reload_register = s_r.aux_cnt;

      // Sticky status: a new event beats a clear in the same cycle
      events                  = '0;
      events[INT_CORE_WRAP]   = core_wrap;
      events[INT_AUX_WRAP]    = aux_wrap;
      events[INT_CAPTURE]     = cap_trig;
      s_nxt.int_stat = (s_r.int_stat & ~clr_mask) | events;
      s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_en);

      // APB answer: one wait cycle, then pready with data or error
      s_nxt.pready  = rd_go;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = 32'h0000_0000;
      if (rd_go)
      begin
         case (I_PADDR)
            ADDR_AUX_CTL:  s_nxt.prdata[CTL_W-1:0]   = s_r.aux_ctl;
            ADDR_CORE_CTL: s_nxt.prdata[CTL_W-1:0]   = s_r.core_ctl;
            ADDR_PRESC:    s_nxt.prdata[DTC_PSW-1:0] = s_r.presc;
            ADDR_CAP_CTL:  s_nxt.prdata[CAP_W-1:0]   = s_r.cap_ctl;
            ADDR_AUX_CNT:  s_nxt.prdata[DTC_TW-1:0]  = s_r.aux_cnt;
            ADDR_CORE_CNT: s_nxt.prdata[DTC_TW-1:0]  = s_r.core_cnt;
            ADDR_CAPTURE_RELOAD_REGISTER:   s_nxt.prdata[DTC_TW-1:0]  = s_r.capture_reload_register;
            ADDR_INT_STAT: s_nxt.prdata[INT_W-1:0]   = s_r.int_stat;
            ADDR_INT_EN:   s_nxt.prdata[INT_W-1:0]   = s_r.int_en;
            ADDR_INT_CLR:  s_nxt.prdata              = 32'h0000_0000;
            default:       s_nxt.pslverr             = 1'b1;
         endcase
      end
   end

   // Single state register; asynchronous reset to constants only
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         s_r          <= '0;
         s_r.aux_ctl  <= CTL_RST;
         s_r.core_ctl <= CTL_RST;
         s_r.presc    <= PRESC_RST;
         s_r.cap_ctl  <= CAP_RST;
      end
      else
         s_r <= s_nxt;
   end

   // Outputs straight from flip-flops
   assign O_PRDATA              = s_r.prdata;
   assign O_PREADY              = s_r.pready;
   assign O_PSLVERR             = s_r.pslverr;
   assign O_TOGGLE_LATCH_OUTPUT = s_r.tl;
   assign O_CC_UNIT_TIMERS_CLK  = s_r.core_wrap;
   assign O_IRQ                 = s_r.irq;
endmodule
`default_nettype wire

//--- verif/dtc_checker.sv
// Port-level assertions for the dual timer with capture/reload.
// Assumes it is bound to dtc_top and sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none
module dtc_checker (
   input  wire logic        I_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic [31:0] O_PRDATA,
   input  wire logic        O_PREADY,
   input  wire logic        O_PSLVERR,
   input  wire logic        O_TOGGLE_LATCH_OUTPUT,
   input  wire logic        O_CC_UNIT_TIMERS_CLK
);
   // One clock domain, so clock and reset are given once here
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   // Bus answer lands exactly one edge after the access is seen
   ready_answer_a: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
      else $error("bus access not answered on time");
   // Ready only inside a held access phase
   ready_cause_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PENABLE))
      else $error("ready without an access");
   ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   // Idle bus carries no data and no error
   idle_quiet_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0 && !O_PSLVERR)
      else $error("data or error outside an answer");
   // A latch flip shows in the same cycle as the outward count pulse
   latch_wrap_a: assert property ($changed(O_TOGGLE_LATCH_OUTPUT) |-> O_CC_UNIT_TIMERS_CLK)
      else $error("wrap pulse missing after latch flip");
   wrap_cause_a: assert property (O_CC_UNIT_TIMERS_CLK
      |-> O_TOGGLE_LATCH_OUTPUT != $past(O_TOGGLE_LATCH_OUTPUT))
      else $error("wrap pulse without latch flip");
   wrap_pulse_a: assert property (O_CC_UNIT_TIMERS_CLK |=> !O_CC_UNIT_TIMERS_CLK)
      else $error("wrap pulse longer than one cycle");
   // Two wraps can never be closer than two clocks
   latch_spacing_a: assert property ($changed(O_TOGGLE_LATCH_OUTPUT)
      |=> $stable(O_TOGGLE_LATCH_OUTPUT))
      else $error("latch flipped on consecutive cycles");
endmodule
bind dtc_top dtc_checker dtc_checker_inst (
   .I_CLK                 (I_CLK),
   .I_RESET_N             (I_RESET_N),
   .I_PSEL                (I_PSEL),
   .I_PENABLE             (I_PENABLE),
   .O_PRDATA              (O_PRDATA),
   .O_PREADY              (O_PREADY),
   .O_PSLVERR             (O_PSLVERR),
   .O_TOGGLE_LATCH_OUTPUT (O_TOGGLE_LATCH_OUTPUT),
   .O_CC_UNIT_TIMERS_CLK  (O_CC_UNIT_TIMERS_CLK)
);
`default_nettype wire

//--- verif/dtc_pins.sv
// Behavioural model of the external event, clock and direction pins.
// Assumes the bench calls its tasks; slots follow the SY_ constants.
`timescale 1ns/10ps
`default_nettype none
module dtc_pins
   import dtc_pkg::*;
(
   input  wire logic            i_clk,
   output logic     [SY_N-1:0]  o_pin
);
   // Pins idle low; the core pins are driven from this model as well
   initial o_pin = '0;
   // Pins move just after an edge; they are asynchronous anyway
   task automatic set_pin(input int k, input logic v);
      @(posedge i_clk);
      o_pin[k] <= v;
   endtask
   // Pulse train; gap sets a prompt or a slow source
   task automatic pulse(input int k, input int n, input int gap);
      repeat (n)
      begin
         set_pin(k, 1'b1);
         repeat (gap) @(posedge i_clk);
         set_pin(k, 1'b0);
         repeat (gap) @(posedge i_clk);
      end
   endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench: APB register tasks plus pin stimulus.
// Assumes dtc_top, dtc_pins and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dtc_pkg::*;
   logic            clk = 1'b0;     // 25 MHz system clock
   logic            rst_n = 1'b0;   // Active-low reset
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            tl;             // Toggle latch output
   logic            cc;             // Wrap pulse outward
   logic            irq;
   logic [SY_N-1:0] pin;            // Event pins from the model
   int              err_count = 0;
   int              checked = 0;

   always #20 clk = ~clk;

   dtc_top dtc_top_inst (
      .I_CLK                          (clk),
      .I_RESET_N                      (rst_n),
      .I_PSEL                         (psel),
      .I_PENABLE                      (penable),
      .I_PWRITE                       (pwrite),
      .I_PADDR                        (paddr),
      .I_PWDATA                       (pwdata),
      .O_PRDATA                       (prdata),
      .O_PREADY                       (pready),
      .O_PSLVERR                      (pslverr),
      .I_CAPTURE_INPUT                (pin[SY_CAP]),
      .I_AUX_CLOCK_INPUT              (pin[SY_AUX_CLK]),
      .I_AUX_DIRECTION_INPUT          (pin[SY_AUX_DIR]),
      .I_FIRST_MODULE_COUNT_INPUT     (pin[SY_FM_CNT]),
      .I_FIRST_MODULE_DIRECTION_INPUT (pin[SY_FM_DIR]),
      .I_CORE_TIMER_CLOCK_INPUT       (pin[SY_CORE_CLK]),
      .I_CORE_TIMER_DIRECTION_INPUT   (pin[SY_CORE_DIR]),
      .O_TOGGLE_LATCH_OUTPUT          (tl),
      .O_CC_UNIT_TIMERS_CLK           (cc),
      .O_IRQ                          (irq)
   );
   dtc_pins dtc_pins_inst (
      .i_clk (clk),
      .o_pin (pin)
   );

   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Compare with case inequality so unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
         err_count++;
      end
   endtask
   // One APB transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Ready, read data and error are all taken at the same rising edge
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            $display("[ERR] %0t bus wait timed out", $time);
            err_count++;
            stop_test();
         end
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp, $sformatf("read %h", a));
   endtask
   // Let pin edges pass the three-stage input path, then settle
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Main sequence
   initial
   begin
      logic [31:0] q;
      logic        e;
      logic        last;
      int          k;
      int          flips;
      int          pulses;
      int          fm;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, unmapped place, width and read-only access
      for (k = 0; k <= 'h24; k += 4)
         rd(8'(k), 32'h0);
      apb(1'b0, 8'h28, 32'h0, q, e);
      chk(32'(e), 32'h1, "unmapped read error");
      chk(q, 32'h0, "unmapped read data");
      apb(1'b1, 8'h28, 32'h0, q, e);
      chk(32'(e), 32'h1, "unmapped write error");
      wr(ADDR_AUX_CNT, 32'hFFFF_A5C3);
      rd(ADDR_AUX_CNT, 32'h0000_A5C3);
      wr(ADDR_INT_STAT, 32'h7);
      rd(ADDR_INT_STAT, 32'h0);
      $display("registers test done");
      // Core on external clock wraps up, reloads and steps the aux timer
      wr(ADDR_INT_EN, 32'h7);
      wr(ADDR_AUX_CNT, 32'h0);
      wr(ADDR_AUX_CTL, 32'h12);
      wr(ADDR_CAPTURE_RELOAD_REGISTER, 32'h1234);
      wr(ADDR_CORE_CNT, 32'hFFFE);
      wr(ADDR_CORE_CTL, 32'h31);
      dtc_pins_inst.pulse(SY_CORE_CLK, 3, 2);
      wt(4);
      chk(32'(tl), 32'h1, "latch after wrap");
      chk(32'(irq), 32'h1, "irq raised");
      rd(ADDR_CORE_CNT, 32'h1235);
      rd(ADDR_AUX_CNT, 32'h1);
      rd(ADDR_INT_STAT, 32'h1);
      wr(ADDR_INT_EN, 32'h0);
      wt(1);
      chk(32'(irq), 32'h0, "irq masked");
      wr(ADDR_INT_CLR, 32'h1);
      rd(ADDR_INT_STAT, 32'h0);
      wr(ADDR_INT_EN, 32'h7);
      wt(1);
      chk(32'(irq), 32'h0, "irq cleared");
      $display("reload test done");
      // Software down on core, pin-driven down on aux
      wr(ADDR_CORE_CNT, 32'h1);
      wr(ADDR_CORE_CTL, 32'h15);
      dtc_pins_inst.pulse(SY_CORE_CLK, 2, 6);
      wt(4);
      rd(ADDR_CORE_CNT, 32'hFFFF);
      chk(32'(tl), 32'h0, "latch after underflow");
      dtc_pins_inst.set_pin(SY_AUX_DIR, 1'b1);
      wr(ADDR_AUX_CTL, 32'h19);
      dtc_pins_inst.pulse(SY_AUX_CLK, 3, 2);
      wt(4);
      rd(ADDR_AUX_CNT, 32'hFFFF);
      rd(ADDR_INT_STAT, 32'h3);
      wr(ADDR_INT_CLR, 32'h7);
      $display("direction test done");
      // Capture on chosen edges, with and without clearing
      wr(ADDR_AUX_CTL, 32'h13);
      wr(ADDR_AUX_CNT, 32'h55);
      wr(ADDR_CAP_CTL, 32'h21);
      dtc_pins_inst.set_pin(SY_CAP, 1'b1);
      wt(4);
      rd(ADDR_CAPTURE_RELOAD_REGISTER, 32'h55);
      wr(ADDR_AUX_CNT, 32'h66);
      dtc_pins_inst.set_pin(SY_CAP, 1'b0);
      wt(4);
      rd(ADDR_CAPTURE_RELOAD_REGISTER, 32'h55);
      wr(ADDR_CAP_CTL, 32'h33);
      dtc_pins_inst.set_pin(SY_CAP, 1'b1);
      wt(4);
      rd(ADDR_CAPTURE_RELOAD_REGISTER, 32'h66);
      rd(ADDR_AUX_CNT, 32'h0);
      rd(ADDR_INT_STAT, 32'h4);
      // First-module trigger sources; the capture pin must be ignored
      for (k = 1; k < 4; k++)
      begin
         wr(ADDR_AUX_CNT, 32'h100 + 32'(k));
         wr(ADDR_CAP_CTL, 32'h23 | 32'(k << 2));
         dtc_pins_inst.set_pin(SY_CAP, ~pin[SY_CAP]);
         wt(4);
         rd(ADDR_CAPTURE_RELOAD_REGISTER, (k == 1) ? 32'h66 : 32'h100 + 32'(k - 1));
         fm = (k == 1) ? SY_FM_CNT : SY_FM_DIR;
         dtc_pins_inst.set_pin(fm, ~pin[fm]);
         wt(4);
         rd(ADDR_CAPTURE_RELOAD_REGISTER, 32'h100 + 32'(k));
      end
      $display("capture test done");
      // Prescaled core wraps every two ticks, four clocks apart
      wr(ADDR_CORE_CTL, 32'h0);
      wr(ADDR_PRESC, 32'h0);
      wr(ADDR_CAPTURE_RELOAD_REGISTER, 32'hFFFE);
      wr(ADDR_CORE_CNT, 32'hFFFF);
      wr(ADDR_CORE_CTL, 32'h30);
      wt(8);
      flips = 0;
      pulses = 0;
      for (k = 0; k < 40; k++)
      begin
         last = tl;
         @(negedge clk);
         if (tl !== last)
            flips++;
         if (cc === 1'b1)
            pulses++;
      end
      chk(32'(flips), 32'd10, "prescaled wrap rate");
      chk(32'(pulses), 32'd10, "outward wrap pulses");
      $display("prescaler test done");
      stop_test();
   end
endmodule
`default_nettype wire
